/* fspc_core.sv */
// Two-channel FIFO serial port core with Avalon-MM register slave
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - Receive bits placed from bit 0 upward
// - Assembled byte moves to receive FIFO automatically
// - Receive shift register has no bus address
// - Receive FIFO: 64 bytes, arrival order
// - Shift register freed after each push
// - Writes to receive port change nothing
// - Empty receive FIFO read returns undefined
// - Full receive FIFO drops new characters
// - Oldest byte loaded, sent bit 0 first
// - Next byte loaded automatically after each
// - Transmit shift register has no bus address
// - Transmit FIFO: 64 bytes, written order
// - Idle transmitter starts on first write
// - Transmit port reads back zero
// - Write to full transmit FIFO ignored
// - Format bits 15 to 11 read zero
// - Sample-rate code picks ticks per bit
// - Format bit 7 selects clocked mode
// - Bit 6 selects 7-bit async characters
// - Seven-bit mode omits transmit bit 7
// - Pins serial only when enables set
// - Bit 5 enables parity, async only
// - Bit 4 picks even or odd parity
// - Bit 3 two stops; receiver checks first
module fspc_core
  import fspc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [1:0]  rxd_pin,
  input  wire logic [1:0]  sck_pin,
  output logic      [1:0]  txd_pin
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [4:0] ratio_of(input logic [2:0] code);
    case (code)
      3'h0:    ratio_of = RATIO_16;
      3'h1:    ratio_of = RATIO_5;
      3'h2:    ratio_of = RATIO_11;
      3'h3:    ratio_of = RATIO_13;
      3'h4:    ratio_of = RATIO_29;
      default: ratio_of = RATIO_16;
    endcase
  endfunction : ratio_of

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: reads take one wait cycle, writes none

  logic        rd_ack_ff;
  logic [31:0] rd_data_ff;
  logic [31:0] ch_rd [2];

  wire rd_go  = avs_read & ~rd_ack_ff & clk_en;
  wire wr_go  = avs_write & clk_en;
  wire [2:0] reg_idx = avs_address[2:0];

  assign avs_waitrequest = (avs_read | avs_write)
                         & (~clk_en | (avs_read & ~rd_ack_ff));
  assign avs_readdata    = rd_data_ff;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rd_ack_ff  <= 1'b0;
      rd_data_ff <= 32'h0;
    end
    else if (clk_en)
    begin
      rd_ack_ff <= avs_read & ~rd_ack_ff;
      if (rd_go)
        rd_data_ff <= ch_rd[avs_address[3]];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channels: index 0 is channel 0, index 1 is channel 2

  genvar c;
  for (c = 0; c < 2; c++)
  begin : g_ch
    logic [15:0] fmt_ff;
    logic [1:0]  ctl_ff;
    logic [7:0]  div_ff;
    logic [7:0]  div_cnt_ff;
    logic        perr_ff;
    logic        ferr_ff;
    logic [1:0]  rxs_ff;
    logic [1:0]  scks_ff;
    logic        sck_d_ff;
    logic [7:0]  tx_mem [FIFO_DEPTH];
    logic [7:0]  rx_mem [FIFO_DEPTH];
    logic [6:0]  tx_wp_ff;
    logic [6:0]  tx_rp_ff;
    logic [6:0]  rx_wp_ff;
    logic [6:0]  rx_rp_ff;
    fspc_tx_e    tx_st_ff;
    logic [7:0]  tx_shift_ff;
    logic [2:0]  tx_bit_ff;
    logic [4:0]  tx_sub_ff;
    logic        tx_par_ff;
    logic        txd_ff;
    fspc_rx_e    rx_st_ff;
    logic [7:0]  rx_shift_ff;
    logic [2:0]  rx_bit_ff;
    logic [4:0]  rx_sub_ff;

    wire hit = (avs_address[3] == (c == 1));
    wire wr  = wr_go & hit;
    wire rd  = rd_go & hit;

    // mode; fields act only in async
    wire sync_m   = fmt_ff[FMT_SYNC];
    wire seven    = ~sync_m & fmt_ff[FMT_CHR];
    wire par_en   = ~sync_m & fmt_ff[FMT_PAR];
    wire odd      = fmt_ff[FMT_ODD];
    wire two_stop = fmt_ff[FMT_STOP2];
    wire tx_go    = ctl_ff[CTL_TX_GO];
    wire rx_go    = ctl_ff[CTL_RX_GO];
    wire [4:0] ratio = ratio_of(fmt_ff[FMT_SR_LO +: 3]);
    wire [4:0] r_last = ratio - 5'h01;
    wire [4:0] r_half = {1'b0, ratio[4:1]};
    wire [2:0] last_bit = seven ? LAST_BIT7 : LAST_BIT8;

    wire tick     = (div_cnt_ff == div_ff);
    wire rx_line  = rxs_ff[1];
    wire sck_rise = scks_ff[1] & ~sck_d_ff;
    wire sck_fall = ~scks_ff[1] & sck_d_ff;

    wire [6:0] tx_cnt   = tx_wp_ff - tx_rp_ff;
    wire [6:0] rx_cnt   = rx_wp_ff - rx_rp_ff;
    wire       tx_empty = (tx_cnt == 7'h00);
    wire       rx_full  = (rx_cnt == FIFO_FULL);
    wire       rx_empty = (rx_cnt == 7'h00);
    wire tx_push = wr & (reg_idx == REG_TXP) & (tx_cnt != FIFO_FULL);
    // idle transmitter takes a byte at once
    wire tx_load = (tx_st_ff == TX_IDLE) & tx_go & ~tx_empty;
    wire rx_push = (rx_st_ff == RX_PUSH) & ~rx_full;
    wire rx_pop  = rd & (reg_idx == REG_RXP) & ~rx_empty;
    wire [7:0] tx_head = tx_mem[tx_rp_ff[5:0]];
    // bit 7 never leaves in seven-bit mode
    wire [7:0] tx_byte = seven ? {1'b0, tx_head[6:0]} : tx_head;
    wire tx_step = sync_m ? sck_fall
                          : (tick & (tx_sub_ff == r_last));
    wire [4:0] rx_tgt = (rx_st_ff == RX_START) ? r_half : r_last;
    wire rx_samp = sync_m ? sck_rise
                          : (tick & (rx_sub_ff == rx_tgt));
    wire rx_perr = par_en & (rx_line != (odd ^ (^rx_shift_ff)));
    wire perr_set = (rx_st_ff == RX_PAR) & rx_samp & rx_perr;
    wire ferr_set = (rx_st_ff == RX_STOP) & rx_samp & ~rx_line;
    wire stat_wr  = wr & (reg_idx == REG_STAT);

    ////////////////////////////////////////////////////////////////////
    // Registers, synchronisers and tick divider

    always_ff @(posedge sys_clk)
    begin
      if (rst)
      begin
        fmt_ff     <= FMT_RESET;
        ctl_ff     <= CTL_RESET;
        div_ff     <= DIV_RESET;
        div_cnt_ff <= 8'h00;
        perr_ff    <= 1'b0;
        ferr_ff    <= 1'b0;
        rxs_ff     <= 2'h3;
        scks_ff    <= 2'h3;
        sck_d_ff   <= 1'b1;
      end
      else if (clk_en)
      begin
        // reserved format bits held at zero
        if (wr & (reg_idx == REG_FMT))
          fmt_ff <= avs_writedata[15:0] & FMT_MASK;
        if (wr & (reg_idx == REG_CTL))
          ctl_ff <= avs_writedata[1:0];
        if (wr & (reg_idx == REG_DIV))
          div_ff <= avs_writedata[7:0];
        div_cnt_ff <= tick ? 8'h00 : div_cnt_ff + 8'h01;
        // Error flags: a set in the clearing cycle wins
        perr_ff <= perr_set | (perr_ff & ~(stat_wr & avs_writedata[ST_PERR]));
        ferr_ff <= ferr_set | (ferr_ff & ~(stat_wr & avs_writedata[ST_FERR]));
        rxs_ff   <= {rxs_ff[0], rxd_pin[c]};
        scks_ff  <= {scks_ff[0], sck_pin[c]};
        sck_d_ff <= scks_ff[1];
      end
    end

    ////////////////////////////////////////////////////////////////////
    // FIFO storage and pointers

    always_ff @(posedge sys_clk)
    begin
      if (clk_en)
      begin
        // transmit bytes stored in write order
        if (tx_push)
          tx_mem[tx_wp_ff[5:0]] <= avs_writedata[7:0];
        // receive bytes stored in arrival order
        if (rx_push)
          rx_mem[rx_wp_ff[5:0]] <= rx_shift_ff;
      end
    end

    always_ff @(posedge sys_clk)
    begin
      if (rst)
      begin
        tx_wp_ff <= 7'h00;
        tx_rp_ff <= 7'h00;
        rx_wp_ff <= 7'h00;
        rx_rp_ff <= 7'h00;
      end
      else if (clk_en)
      begin
        if (tx_push)
          tx_wp_ff <= tx_wp_ff + 7'h01;
        if (tx_load)
          tx_rp_ff <= tx_rp_ff + 7'h01;
        if (rx_push)
          rx_wp_ff <= rx_wp_ff + 7'h01;
        if (rx_pop)
          rx_rp_ff <= rx_rp_ff + 7'h01;
      end
    end

    ////////////////////////////////////////////////////////////////////
    // Transmitter

    always_ff @(posedge sys_clk)
    begin
      if (rst)
      begin
        tx_st_ff    <= TX_IDLE;
        tx_shift_ff <= 8'h00;
        tx_bit_ff   <= 3'h0;
        tx_sub_ff   <= 5'h00;
        tx_par_ff   <= 1'b0;
        txd_ff      <= 1'b1;
      end
      else if (clk_en)
      begin
        if (tx_step | (tx_st_ff == TX_IDLE))
          tx_sub_ff <= 5'h00;
        else if (tick)
          tx_sub_ff <= tx_sub_ff + 5'h01;
        if (~tx_go)
        begin
          tx_st_ff <= TX_IDLE;
          txd_ff   <= 1'b1;
        end
        else
        begin
          case (tx_st_ff)
            TX_IDLE:
            begin
              if (tx_load)
              begin
                tx_shift_ff <= tx_byte;
                tx_bit_ff   <= 3'h0;
                tx_par_ff   <= odd ^ (^tx_byte);
                tx_st_ff    <= sync_m ? TX_DATA : TX_START;
                txd_ff      <= sync_m ? tx_byte[0] : 1'b0;
              end
            end
            TX_START:
              if (tx_step)
              begin
                tx_st_ff <= TX_DATA;
                txd_ff   <= tx_shift_ff[0];
              end
            TX_DATA:
              if (tx_step)
              begin
                if (tx_bit_ff == last_bit)
                begin
                  tx_st_ff <= sync_m ? TX_IDLE
                                     : (par_en ? TX_PAR : TX_STOP);
                  txd_ff   <= par_en ? tx_par_ff : 1'b1;
                end
                else
                begin
                  tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
                  tx_bit_ff   <= tx_bit_ff + 3'h1;
                  txd_ff      <= tx_shift_ff[1];
                end
              end
            TX_PAR:
              if (tx_step)
              begin
                tx_st_ff <= TX_STOP;
                txd_ff   <= 1'b1;
              end
            TX_STOP:
              if (tx_step)
                tx_st_ff <= two_stop ? TX_STOP2 : TX_IDLE;
            TX_STOP2:
              if (tx_step)
                tx_st_ff <= TX_IDLE;
            default:
              tx_st_ff <= TX_IDLE;
          endcase
        end
      end
    end

    assign txd_pin[c] = txd_ff;

    ////////////////////////////////////////////////////////////////////
    // Receiver

    always_ff @(posedge sys_clk)
    begin
      if (rst)
      begin
        rx_st_ff    <= RX_IDLE;
        rx_shift_ff <= 8'h00;
        rx_bit_ff   <= 3'h0;
        rx_sub_ff   <= 5'h00;
      end
      else if (clk_en)
      begin
        if (rx_samp | (rx_st_ff == RX_IDLE))
          rx_sub_ff <= 5'h00;
        else if (tick)
          rx_sub_ff <= rx_sub_ff + 5'h01;
        if (~rx_go)
          rx_st_ff <= RX_IDLE;
        else
        begin
          case (rx_st_ff)
            RX_IDLE:
            begin
              rx_shift_ff <= 8'h00;
              rx_bit_ff   <= 3'h0;
              if (sync_m)
                rx_st_ff <= RX_DATA;
              else if (~rx_line)
                rx_st_ff <= RX_START;
            end
            RX_START:
              if (rx_samp)
                rx_st_ff <= rx_line ? RX_IDLE : RX_DATA;
            RX_DATA:
              if (rx_samp)
              begin
                // bit n of character into bit n
                rx_shift_ff[rx_bit_ff] <= rx_line;
                rx_bit_ff <= rx_bit_ff + 3'h1;
                if (rx_bit_ff == last_bit)
                  rx_st_ff <= sync_m ? RX_PUSH
                                     : (par_en ? RX_PAR : RX_STOP);
              end
            RX_PAR:
              if (rx_samp)
                rx_st_ff <= RX_STOP;
            RX_STOP:
              if (rx_samp)
                rx_st_ff <= RX_PUSH;
            RX_PUSH:
              // shift register freed for next character
              rx_st_ff <= RX_IDLE;
            default:
              rx_st_ff <= RX_IDLE;
          endcase
        end
      end
    end

    ////////////////////////////////////////////////////////////////////
    // Read-back

    // receive port has no write path
    // empty receive FIFO gives stale entry
    wire [31:0] stat_word = {9'h0, tx_cnt, 1'b0, rx_cnt, 5'h0,
                             (tx_st_ff != TX_IDLE), ferr_ff, perr_ff};
    assign ch_rd[c] =
      (reg_idx == REG_FMT)  ? {16'h0, fmt_ff} :
      (reg_idx == REG_CTL)  ? {30'h0, ctl_ff} :
      (reg_idx == REG_DIV)  ? {24'h0, div_ff} :
      (reg_idx == REG_RXP)  ? {24'h0, rx_mem[rx_rp_ff[5:0]]} :
      (reg_idx == REG_STAT) ? stat_word : 32'h0;
  end

endmodule : fspc_core

/* fspc_pkg.sv */
// Shared constants and state types for the FIFO serial port core
package fspc_pkg;

  // Word index of each per-channel register (address bit 3 picks the channel)
  localparam logic [2:0] REG_FMT  = 3'h0;
  localparam logic [2:0] REG_CTL  = 3'h1;
  localparam logic [2:0] REG_DIV  = 3'h2;
  localparam logic [2:0] REG_TXP  = 3'h3;
  localparam logic [2:0] REG_RXP  = 3'h4;
  localparam logic [2:0] REG_STAT = 3'h5;

  // Format register fields
  localparam int FMT_SR_LO  = 8;
  localparam int FMT_SYNC   = 7;
  localparam int FMT_CHR    = 6;
  localparam int FMT_PAR    = 5;
  localparam int FMT_ODD    = 4;
  localparam int FMT_STOP2  = 3;
  localparam logic [15:0] FMT_MASK  = 16'h07ff;
  localparam logic [15:0] FMT_RESET = 16'h0000;

  // Control register fields
  localparam int CTL_TX_GO = 0;
  localparam int CTL_RX_GO = 1;
  localparam logic [1:0] CTL_RESET = 2'h0;
  localparam logic [7:0] DIV_RESET = 8'h00;

  // Status register fields
  localparam int ST_PERR  = 0;
  localparam int ST_FERR  = 1;
  localparam int ST_TXBSY = 2;
  localparam int ST_RXCNT = 8;
  localparam int ST_TXCNT = 16;

  // Sampling ratios, in sample ticks per bit
  localparam logic [4:0] RATIO_16 = 5'h10;
  localparam logic [4:0] RATIO_5  = 5'h05;
  localparam logic [4:0] RATIO_11 = 5'h0b;
  localparam logic [4:0] RATIO_13 = 5'h0d;
  localparam logic [4:0] RATIO_29 = 5'h1d;

  localparam int FIFO_DEPTH = 64;
  localparam logic [6:0] FIFO_FULL = 7'h40;
  localparam logic [2:0] LAST_BIT8 = 3'h7;
  localparam logic [2:0] LAST_BIT7 = 3'h6;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_STOP2
  } fspc_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_PUSH
  } fspc_rx_e;

endpackage : fspc_pkg

/* fspc_core_checker.sv */
// Port-level assertions for the FIFO serial port core
`timescale 1ns/1ps
module fspc_core_checker
  import fspc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  rxd_pin,
  input wire logic [1:0]  sck_pin,
  input wire logic [1:0]  txd_pin
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the transmit enables, one per channel
  logic [1:0] ten_ff;
  logic [1:0] nxt_ten;
  wire        wr_ok = avs_write & clk_en & ~avs_waitrequest;
  wire        rd_ok = avs_read & clk_en & ~avs_waitrequest;
  wire        ctl0  = wr_ok & (avs_address == {1'b0, REG_CTL});
  wire        ctl2  = wr_ok & (avs_address == {1'b1, REG_CTL});

  assign nxt_ten[0] = ctl0 ? avs_writedata[CTL_TX_GO] : ten_ff[0];
  assign nxt_ten[1] = ctl2 ? avs_writedata[CTL_TX_GO] : ten_ff[1];

  always_ff @(posedge sys_clk)
    if (rst)
      ten_ff <= 2'h0;
    else
      ten_ff <= nxt_ten;

  ////////////////////////////////////////////////////////////////////////////
  a_write_no_wait: assert property (avs_write && !avs_read && clk_en |-> !avs_waitrequest)
    else $error("write stalled");
  a_stall_clk_off: assert property ((avs_read || avs_write) && !clk_en |-> avs_waitrequest)
    else $error("request answered while frozen");
  a_idle_no_wait: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_read_one_wait: assert property (avs_read && avs_waitrequest && clk_en ##1 avs_read && clk_en
    |-> !avs_waitrequest)
    else $error("read not answered in second cycle");
  a_data_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without read");
  a_fmt_top_zero: assert property (
    rd_ok && avs_address[2:0] == REG_FMT |-> avs_readdata[15:11] == 5'h00)
    else $error("format upper bits not zero");
  a_txport_zero: assert property (
    rd_ok && avs_address[2:0] == REG_TXP |-> avs_readdata == 32'h0)
    else $error("transmit port read back data");
  a_unmapped_zero: assert property (
    rd_ok && avs_address[2:1] == 2'h3 |-> avs_readdata == 32'h0)
    else $error("unmapped index returned data");
  a_tx_off_idle: assert property (
    1'b1 |-> ((~ten_ff & ~$past(ten_ff)) & ~txd_pin) == 2'h0)
    else $error("transmit line active while disabled");
  a_reset_idle: assert property (disable iff (1'b0) rst && clk_en |=> txd_pin == 2'h3)
    else $error("transmit line not idle after reset");
endmodule : fspc_core_checker

bind fspc_core fspc_core_checker i_chk (
  .sys_clk         (sys_clk),
  .rst             (rst),
  .clk_en          (clk_en),
  .avs_address     (avs_address),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_writedata   (avs_writedata),
  .avs_readdata    (avs_readdata),
  .avs_waitrequest (avs_waitrequest),
  .rxd_pin         (rxd_pin),
  .sck_pin         (sck_pin),
  .txd_pin         (txd_pin)
);

/* fspc_peer.sv */
// Remote serial partner: async sender on line 0, clocked master on line 1
`timescale 1ns/1ps
module fspc_peer (
  input  wire logic       sys_clk,
  input  wire logic [1:0] txd_pin,
  output logic      [1:0] rxd_pin,
  output logic      [1:0] sck_pin
);
  initial
  begin
    rxd_pin = 2'h3;
    sck_pin = 2'h3;
  end

  // One 8N1 frame, p cycles per bit, line rests at mark
  task automatic send(input logic [7:0] b, input int p);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge sys_clk);
      rxd_pin[0] <= f[i];
      repeat (p - 1) @(posedge sys_clk);
    end
  endtask : send

  // Eight clocks of 160 ns; clock rests high between frames
  task automatic xfer(input logic [7:0] b, output logic [7:0] g);
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      g[i] = txd_pin[1];
      sck_pin[1] <= 1'b0;
      rxd_pin[1] <= b[i];
      repeat (4) @(posedge sys_clk);
      sck_pin[1] <= 1'b1;
      repeat (3) @(posedge sys_clk);
    end
    rxd_pin[1] <= ~b[7];
  endtask : xfer
endmodule : fspc_peer

/* tb_top.sv */
// Self-checking bench for the FIFO serial port core
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  rxd_pin;
  logic [1:0]  sck_pin;
  logic [1:0]  txd_pin;
  int          error_cnt = 0;
  int          num_checks = 0;

  always #10 sys_clk = ~sys_clk;

  fspc_core i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rxd_pin(rxd_pin), .sck_pin(sck_pin),
    .txd_pin(txd_pin));
  fspc_peer i_peer (.sys_clk(sys_clk), .txd_pin(txd_pin), .rxd_pin(rxd_pin),
    .sck_pin(sck_pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk

  task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= r;
    avs_write     <= ~r;
    i = 0;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && i < 500)
    begin
      @(posedge sys_clk);
      i++;
    end
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (i >= 500)
    begin
      error_cnt++;
      test_done();
    end
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    bus(1'b1, a, 32'h0, q);
  endtask : rd

  // Expected line levels; f is {seven, parity, odd, two stops}
  function automatic int frame(input logic [7:0] b, input logic [3:0] f,
                               output logic [11:0] e);
    int n;
    n = 1;
    e = 12'h0;
    for (int i = 0; i < (f[3] ? 7 : 8); i++)
    begin
      e[n] = b[i];
      n++;
    end
    if (f[2])
    begin
      e[n] = ^(b & (f[3] ? 8'h7f : 8'hff)) ^ f[1];
      n++;
    end
    e[n] = 1'b1;
    e[n + 1] = f[0];
    return n + 1 + int'(f[0]);
  endfunction : frame

  task automatic get_tx(input int n, input int p, output logic [11:0] g);
    int i;
    i = 0;
    g = 12'h0;
    while (txd_pin[0] !== 1'b0 && i < 5000)
    begin
      @(posedge sys_clk);
      i++;
    end
    if (i >= 5000)
    begin
      error_cnt++;
      test_done();
    end
    repeat (p / 2) @(posedge sys_clk);
    for (int k = 0; k < n; k++)
    begin
      g[k] = txd_pin[0];
      if (k < n - 1)
        repeat (p) @(posedge sys_clk);
    end
  endtask : get_tx

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_regs;
    logic [31:0] q;
    rd(4'h0, q);
    chk("format reset", 32'h0, q);
    wr(4'h0, 32'hffff);
    rd(4'h0, q);
    chk("format bits", 32'h07ff, q);
    rd(4'h3, q);
    chk("tx port read", 32'h0, q);
    rd(4'he, q);
    chk("unmapped read", 32'h0, q);
    wr(4'h4, 32'h5a);
    rd(4'h5, q);
    chk("rx count", 32'h0, {25'h0, q[14:8]});
    clk_en <= 1'b0;
    fork
      rd(4'h0, q);
      begin
        repeat (3) @(posedge sys_clk);
        clk_en <= 1'b1;
      end
    join
    chk("format frozen read", 32'h07ff, q);
    wr(4'h0, 32'h0);
  endtask : s_regs

  task automatic s_tx;
    int          p [5] = '{16, 5, 11, 13, 29};
    logic [3:0]  f [4] = '{4'hc, 4'h7, 4'h9, 4'he};
    logic [11:0] e;
    logic [11:0] g;
    int          n;
    wr(4'h1, 32'h1);
    for (int c = 0; c < 5; c++)
    begin
      wr(4'h0, c << 8);
      wr(4'h3, 32'h96 + c);
      n = frame(8'(8'h96 + c), 4'h0, e);
      get_tx(n, p[c], g);
      chk("ratio frame", {20'h0, e}, {20'h0, g});
      repeat (30) @(posedge sys_clk);
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(4'h0, 32'h100 | (f[k] << 3));
      wr(4'h3, 32'h3a + k);
      wr(4'h3, 32'hc5 - k);
      n = frame(8'(8'h3a + k), f[k], e);
      get_tx(n, 5, g);
      chk("first frame", {20'h0, e}, {20'h0, g});
      n = frame(8'(8'hc5 - k), f[k], e);
      get_tx(n, 5, g);
      chk("second frame", {20'h0, e}, {20'h0, g});
      repeat (30) @(posedge sys_clk);
    end
  endtask : s_tx

  task automatic s_rx;
    logic [31:0] q;
    wr(4'h0, 32'h100);
    wr(4'h1, 32'h3);
    for (int i = 0; i < 65; i++)
      i_peer.send(8'(8'h11 + i), 5);
    repeat (20) @(posedge sys_clk);
    rd(4'h5, q);
    chk("rx count full", 32'h40, {25'h0, q[14:8]});
    for (int i = 0; i < 64; i++)
    begin
      rd(4'h4, q);
      chk("rx byte", 32'h11 + i, {24'h0, q[7:0]});
    end
  endtask : s_rx

  // Parity on receive, divided tick, sticky error flag and its clear
  task automatic s_rx_par;
    logic [31:0] q;
    wr(4'h2, 32'h1);
    wr(4'h0, 32'h120);
    i_peer.send(8'h13, 10);
    repeat (30) @(posedge sys_clk);
    rd(4'h5, q);
    chk("parity good", 32'h0, {30'h0, q[1:0]});
    i_peer.send(8'h11, 10);
    repeat (30) @(posedge sys_clk);
    rd(4'h5, q);
    chk("parity error", 32'h1, {30'h0, q[1:0]});
    wr(4'h5, 32'h3);
    rd(4'h5, q);
    chk("error cleared", 32'h0, {30'h0, q[1:0]});
    rd(4'h4, q);
    chk("parity byte 1", 32'h13, {24'h0, q[7:0]});
    rd(4'h4, q);
    chk("parity byte 2", 32'h11, {24'h0, q[7:0]});
  endtask : s_rx_par

  // Clocked mode ignores the length and parity bits
  task automatic s_sync;
    logic [31:0] q;
    logic [7:0]  g;
    wr(4'h8, 32'he0);
    wr(4'h9, 32'h3);
    wr(4'hb, 32'hda);
    i_peer.xfer(8'hc3, g);
    chk("sync tx", 32'hda, {24'h0, g});
    repeat (10) @(posedge sys_clk);
    rd(4'hc, q);
    chk("sync rx", 32'hc3, {24'h0, q[7:0]});
    for (int i = 0; i < 66; i++)
      wr(4'hb, i);
    rd(4'hd, q);
    chk("tx count full", 32'h40, {25'h0, q[22:16]});
    for (int i = 0; i < 2; i++)
    begin
      i_peer.xfer(8'h00, g);
      chk("sync order", i, {24'h0, g});
    end
  endtask : s_sync

  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    s_regs();
    s_tx();
    s_rx();
    s_rx_par();
    s_sync();
    test_done();
  end
endmodule : tb_top
